// >>> hdl/lvdc_control.sv
// Low-voltage detect control: APB register file, trip-level routing,
// power enable, reference-stable gating and sticky interrupt flag.
// Assumes the analog comparator, divider and reference sit outside and
// report asynchronous levels; one 25 MHz clock, async active-low reset.
//
// Added by the designer: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none

module lvdc_control (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        comparatorLow,
  input  wire logic        referenceStable,
  output var  logic        detectorPowerEnable,
  output var  logic [3:0]  dividerTapSelect,
  output var  logic        externalTripSelect,
  output var  logic        lowVoltageIrq,
  output var  logic        wakeRequest,
  output var  logic        vectorRequest
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [3:0]  tripLevelSelect;
    logic        powerEnable;
    logic        irqFlag;
    logic        irqEnable;
    logic        globalIrqEnable;
    logic        sleeping;
    logic [31:0] readData;
    logic        ready;
    logic        slvErr;
    logic [3:0]  tapOut;
    logic        extOut;
    logic        pwrOut;
    logic        irqOut;
    logic        wakeOut;
    logic        vectorOut;
  } lvdc_state_t;

  lvdc_state_t state;
  lvdc_state_t next_state;
  logic [1:0]  syncLevels;
  logic        cmpLowSync;
  logic        refStableSync;

  // Both analog levels cross into the clock domain before use.
  lvdc_sync #(
    .WIDTH (2)
  ) uSync (
    .clk     (clk),
    .rst_n   (rst_n),
    .asyncIn ({comparatorLow, referenceStable}),
    .syncOut (syncLevels)
  );
  assign cmpLowSync    = syncLevels[1];
  assign refStableSync = syncLevels[0];

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  // Register decode, flag update and output staging in one place.
  always_comb
  begin
    logic        access;
    logic        wrAccess;
    logic        stableView;
    logic        tripEvent;
    logic        clearFlag;
    logic [3:0]  tripNew;
    logic        pwrNew;
    logic        ieNew;
    logic        gieNew;
    logic        sleepNew;
    logic        flagNew;
    access     = 1'b0;
    wrAccess   = 1'b0;
    stableView = 1'b0;
    tripEvent  = 1'b0;
    clearFlag  = 1'b0;
    tripNew    = state.tripLevelSelect;
    pwrNew     = state.powerEnable;
    ieNew      = state.irqEnable;
    gieNew     = state.globalIrqEnable;
    sleepNew   = state.sleeping;
    next_state = state;

    // Access phase completes in its first cycle: ready comes from the
    // setup cycle so that a transfer takes exactly two cycles.
    access     = psel && penable && state.ready;
    wrAccess   = access && pwrite;

    // Stable only reads high while powered and the reference says so;
    // settling is signalled by the reference, never by counting clocks.
    stableView = state.powerEnable && refStableSync;

    // Trip only counts once detection is valid; it works in sleep too.
    tripEvent  = stableView && cmpLowSync;

    // Writes. Only byte lane 0 holds implemented bits.
    if (wrAccess && pstrb[0])
    begin
      unique case (paddr)
        lvdc_pkg::LVDC_ADDR_CONTROL:
        begin
          // Bits 7..5 are not writable.
          tripNew = pwdata[lvdc_pkg::LVDC_TRIP_LSB +: lvdc_pkg::LVDC_TRIP_W];
          pwrNew  = pwdata[lvdc_pkg::LVDC_PWR_BIT];
        end
        lvdc_pkg::LVDC_ADDR_IRQ_STAT:
          clearFlag = pwdata[lvdc_pkg::LVDC_IRQ_TRIP_BIT];
        lvdc_pkg::LVDC_ADDR_IRQ_MASK:
          ieNew = pwdata[lvdc_pkg::LVDC_IRQ_TRIP_BIT];
        lvdc_pkg::LVDC_ADDR_SYSTEM:
        begin
          gieNew   = pwdata[lvdc_pkg::LVDC_SYS_GIE_BIT];
          sleepNew = pwdata[lvdc_pkg::LVDC_SYS_SLEEP_BIT];
        end
        default:
          clearFlag = 1'b0;
      endcase
    end

    // Sticky flag: write-one clears, but a trip in the same cycle wins.
    flagNew = tripEvent || (state.irqFlag && !clearFlag);

    // A wake leaves sleep at once, whatever the interrupt enables say.
    if (flagNew && state.sleeping)
    begin
      sleepNew = 1'b0;
    end

    next_state.tripLevelSelect = tripNew;
    next_state.powerEnable     = pwrNew;
    next_state.irqEnable       = ieNew;
    next_state.globalIrqEnable = gieNew;
    next_state.sleeping        = sleepNew;
    next_state.irqFlag         = flagNew;

    // Read data is staged in the setup cycle and shown in the access one.
    next_state.ready    = psel && !penable;
    next_state.slvErr   = 1'b0;
    next_state.readData = '0;
    if (psel && !penable)
    begin
      unique case (paddr)
        lvdc_pkg::LVDC_ADDR_CONTROL:
        begin
          // Bits 7 and 6 stay zero.
          next_state.readData[lvdc_pkg::LVDC_TRIP_LSB +: lvdc_pkg::LVDC_TRIP_W] = state.tripLevelSelect;
          next_state.readData[lvdc_pkg::LVDC_PWR_BIT]    = state.powerEnable;
          next_state.readData[lvdc_pkg::LVDC_STABLE_BIT] = stableView;
        end
        lvdc_pkg::LVDC_ADDR_IRQ_STAT:
          next_state.readData[lvdc_pkg::LVDC_IRQ_TRIP_BIT] = state.irqFlag;
        lvdc_pkg::LVDC_ADDR_IRQ_MASK:
          next_state.readData[lvdc_pkg::LVDC_IRQ_TRIP_BIT] = state.irqEnable;
        lvdc_pkg::LVDC_ADDR_SYSTEM:
        begin
          next_state.readData[lvdc_pkg::LVDC_SYS_GIE_BIT]   = state.globalIrqEnable;
          next_state.readData[lvdc_pkg::LVDC_SYS_SLEEP_BIT] = state.sleeping;
        end
        default:
          next_state.slvErr = 1'b1;
      endcase
    end

    // Analog routing: code 1111 picks the pin, others a divider tap.
    next_state.extOut = (tripNew == lvdc_pkg::LVDC_TRIP_EXTERNAL);
    // Tap index rises with code, so higher codes trip higher; the pin
    // code parks the divider on tap zero to keep the mux quiet.
    next_state.tapOut = next_state.extOut ? '0 : tripNew;
    next_state.pwrOut = pwrNew;

    // Level interrupt while flag and enable are both set.
    next_state.irqOut    = flagNew && ieNew;
    // Vectoring also needs the global enable; a wake does not.
    next_state.vectorOut = flagNew && ieNew && gieNew;
    next_state.wakeOut   = flagNew && state.sleeping;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Any reset returns control to 0x05, with the detector powered down.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state                 <= '0;
      state.tripLevelSelect <= lvdc_pkg::LVDC_TRIP_RESET;
      state.tapOut          <= lvdc_pkg::LVDC_TRIP_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Every output comes from the state register.
  assign prdata              = state.readData;
  assign pready              = state.ready;
  assign pslverr             = state.slvErr;
  assign detectorPowerEnable = state.pwrOut;
  assign dividerTapSelect    = state.tapOut;
  assign externalTripSelect  = state.extOut;
  assign lowVoltageIrq       = state.irqOut;
  assign wakeRequest         = state.wakeOut;
  assign vectorRequest       = state.vectorOut;
endmodule // lvdc_control
`default_nettype wire

// >>> hdl/lvdc_pkg.sv
// Package for the low-voltage detect control block.
// Assumes a 32-bit APB slave; registers are one aligned word each.
`default_nettype none
package lvdc_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] LVDC_ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] LVDC_ADDR_IRQ_STAT  = 8'h04;
  localparam logic [7:0] LVDC_ADDR_IRQ_MASK  = 8'h08;
  localparam logic [7:0] LVDC_ADDR_SYSTEM    = 8'h0C;
  // ----------------------------------------
  // Control register fields
  // ----------------------------------------
  localparam int          LVDC_TRIP_LSB      = 0;
  localparam int          LVDC_TRIP_W        = 4;
  localparam int          LVDC_PWR_BIT       = 4;
  localparam int          LVDC_STABLE_BIT    = 5;
  localparam int          LVDC_CTRL_W        = 8;
  localparam logic [3:0]  LVDC_TRIP_RESET    = 4'h5;
  localparam logic [3:0]  LVDC_TRIP_EXTERNAL = 4'hF;
  // ----------------------------------------
  // System register fields
  // ----------------------------------------
  localparam int          LVDC_SYS_GIE_BIT   = 0;
  localparam int          LVDC_SYS_SLEEP_BIT = 1;
  // Status and mask share one bit: the trip event.
  localparam int          LVDC_IRQ_TRIP_BIT  = 0;
endpackage : lvdc_pkg
`default_nettype wire

// >>> hdl/lvdc_sync.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes the input is a slow level from the analog side.
`timescale 1ns/1ps
`default_nettype none
module lvdc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] asyncIn,
  output var  logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // The first stage feeds only the second one, to contain metastability.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1  <= '0;
      syncOut <= '0;
    end
    else
    begin
      stage1  <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule // lvdc_sync
`default_nettype wire

// >>> bench/lvdc_control_asserts.sv
// Checker for the low-voltage detect control block ports.
// Assumes one clock domain and the designer's two-cycle APB timing.
`timescale 1ns/1ps
`default_nettype none
module lvdc_control_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       psel,
  input wire logic       pwrite,
  input wire logic       referenceStable,
  input wire logic       detectorPowerEnable,
  input wire logic [3:0] dividerTapSelect,
  input wire logic       externalTripSelect,
  input wire logic       lowVoltageIrq,
  input wire logic       wakeRequest,
  input wire logic       vectorRequest
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // Outputs that only software may move, and the flag chain that must not leak.
  a_ext_no_tap: assert property (externalTripSelect |-> dividerTapSelect == 4'h0)
    else $error("external route with a divider tap selected");
  a_tap_by_write: assert property ($changed(dividerTapSelect) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("tap select moved without a write");
  a_power_by_write: assert property ($changed(detectorPowerEnable) |-> $past(psel && pwrite) || $past(psel && pwrite, 2))
    else $error("power enable moved without a write");
  a_off_no_wake: assert property ((!detectorPowerEnable)[*5] |-> !wakeRequest)
    else $error("wake while detector off");
  a_unstable_no_wake: assert property ((!referenceStable)[*5] |-> !wakeRequest)
    else $error("wake while reference unsettled");
  a_vector_needs_irq: assert property (vectorRequest |-> lowVoltageIrq)
    else $error("vector without interrupt");
  a_wake_pulse: assert property (wakeRequest |=> !wakeRequest)
    else $error("wake held longer than one cycle");
  a_irq_sticky: assert property (lowVoltageIrq && !psel && !$past(psel) |=> lowVoltageIrq)
    else $error("interrupt dropped without a write");
endmodule // lvdc_control_asserts
bind lvdc_control lvdc_control_asserts u_lvdc_control_asserts (.clk(clk), .rst_n(rst_n), .psel(psel),
  .pwrite(pwrite), .referenceStable(referenceStable), .detectorPowerEnable(detectorPowerEnable),
  .dividerTapSelect(dividerTapSelect), .externalTripSelect(externalTripSelect),
  .lowVoltageIrq(lowVoltageIrq), .wakeRequest(wakeRequest), .vectorRequest(vectorRequest));
`default_nettype wire

// >>> bench/test_low_voltage_detect_control.sv
// Self-checking bench for the low-voltage detect control block.
// Assumes the APB slave answers without wait states and analog pins are levels.
`timescale 1ns/1ps
`default_nettype none
module test_low_voltage_detect_control;
  logic        clk, rst_n, psel, penable, pwrite, comparatorLow, referenceStable, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, dividerTapSelect;
  logic        pready, pslverr, detectorPowerEnable, externalTripSelect, lowVoltageIrq, wakeRequest, vectorRequest;
  int          n_errors, n_checks, i;
  // Rows: control write, expected readback, expected tap.
  logic [7:0]  rowW [4] = '{8'hEF, 8'hC0, 8'h1E, 8'h35};
  logic [7:0]  rowR [4] = '{8'h0F, 8'h00, 8'h1E, 8'h15};
  logic [3:0]  rowT [4] = '{4'h0, 4'h0, 4'hE, 4'h5};
  lvdc_control u_lvdc_control (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .comparatorLow(comparatorLow), .referenceStable(referenceStable), .detectorPowerEnable(detectorPowerEnable),
    .dividerTapSelect(dividerTapSelect), .externalTripSelect(externalTripSelect), .lowVoltageIrq(lowVoltageIrq),
    .wakeRequest(wakeRequest), .vectorRequest(vectorRequest));
  // 25 MHz clock.
  always #20 clk = ~clk;
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One APB transfer; the wait is bounded so a silent slave cannot hang us.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    // Outputs are looked at mid-cycle, where they are settled; what stands
    // there is what the next rising edge samples.
    do
    begin
      @(negedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      n_errors++;
      $display("ERROR pready expected 1 seen %b", pready);
    end
    rd = prdata;
    err = pslverr;
    // Release only after the completing rising edge.
    @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; pstrb = 4'hF;
    comparatorLow = 0; referenceStable = 0; n_errors = 0; n_checks = 0;
    repeat (10) @(posedge clk);
    chk("outs in reset", {detectorPowerEnable, externalTripSelect, lowVoltageIrq, dividerTapSelect}, 7'h05);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl reset", rd, 32'h0000_0005);
    for (i = 0; i < 4; i++)
    begin
      apb(1'b1, 8'h00, {24'h00_0000, rowW[i]});
      apb(1'b0, 8'h00, 32'h0000_0000);
      chk("ctrl", rd, {24'h00_0000, rowR[i]});
      chk("tap ext pwr", {dividerTapSelect, externalTripSelect, detectorPowerEnable}, {rowT[i], rowW[i][3:0] == 4'hF, rowR[i][4]});
    end
    // Every trip code: the external route only at the top code.
    for (i = 0; i < 16; i++)
    begin
      apb(1'b1, 8'h00, i);
      repeat (2) @(posedge clk);
      chk("tap code", {externalTripSelect, dividerTapSelect}, (i == 15) ? 5'h10 : i[4:0]);
    end
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk("unmapped", err, 1'b1);
    // A trip before the reference settles must not raise the flag.
    apb(1'b1, 8'h00, 32'h0000_0015);
    comparatorLow <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("flag unsettled", rd, 32'h0000_0000);
    referenceStable <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("stable bit", rd, 32'h0000_0035);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("flag", rd, 32'h0000_0001);
    chk("irq masked", lowVoltageIrq, 1'b0);
    apb(1'b1, 8'h08, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("irq", {lowVoltageIrq, vectorRequest}, 2'b10);
    apb(1'b1, 8'h0C, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("vector", vectorRequest, 1'b1);
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("trip beats clear", rd, 32'h0000_0001);
    comparatorLow <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h04, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("cleared", {lowVoltageIrq, vectorRequest}, 2'b00);
    // Trip while asleep wakes the core and ends sleep.
    apb(1'b1, 8'h0C, 32'h0000_0003);
    comparatorLow <= 1'b1;
    for (i = 0; i < 20 && wakeRequest !== 1'b1; i++) @(posedge clk);
    chk("wake", wakeRequest, 1'b1);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk("sleep ended", rd, 32'h0000_0001);
    // Detector off: no trip, no stable report.
    comparatorLow <= 1'b0;
    repeat (4) @(posedge clk);
    apb(1'b1, 8'h04, 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0005);
    comparatorLow <= 1'b1;
    repeat (6) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk("no trip when off", rd, 32'h0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("stable when off", rd, 32'h0000_0005);
    // Reset in mid-run switches the detector off.
    apb(1'b1, 8'h00, 32'h0000_001F);
    repeat (2) @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    chk("outs mid reset", {detectorPowerEnable, dividerTapSelect}, 5'h05);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk("ctrl after reset", rd, 32'h0000_0005);
    wrap_up;
  end
  // Watchdog well beyond the few hundred cycles the sequence needs.
  initial
  begin
    repeat (3000) @(posedge clk);
    n_errors++;
    wrap_up;
  end
endmodule // test_low_voltage_detect_control
`default_nettype wire
